//--- hdl/phs_defs.svh
// offsets, field positions, reset values and timing counts of the supply sequencer
`ifndef PHS_DEFS_SVH
`define PHS_DEFS_SVH

// ----------------------------------------
// clock and timebase
// ----------------------------------------
`define PHS_CLK_PERIOD_NS 10
`define PHS_TICK_NS 1000000
`define PHS_TICK_CYCLES (`PHS_TICK_NS / `PHS_CLK_PERIOD_NS)

// ----------------------------------------
// delays in ms and their tick counts
// ----------------------------------------
`define PHS_PG_DELAY_MS 200
`define PHS_PG_DELAY_TICKS (`PHS_PG_DELAY_MS * 1000000 / `PHS_TICK_NS)
`define PHS_MAIN_ON_MS 500
`define PHS_MAIN_ON_TICKS (`PHS_MAIN_ON_MS * 1000000 / `PHS_TICK_NS)
`define PHS_LAG_33_MS 20
`define PHS_LAG_33_TICKS (`PHS_LAG_33_MS * 1000000 / `PHS_TICK_NS)
`define PHS_MAINS_HOLD_MS 16
`define PHS_MAINS_HOLD_TICKS (`PHS_MAINS_HOLD_MS * 1000000 / `PHS_TICK_NS + 1)
`define PHS_WARN_MS 1
`define PHS_WARN_TICKS (`PHS_WARN_MS * 1000000 / `PHS_TICK_NS + 1)
`define PHS_OFF_MIN_MS 1000
`define PHS_OFF_MIN_TICKS (`PHS_OFF_MIN_MS * 1000000 / `PHS_TICK_NS + 1)

// ----------------------------------------
// register offsets
// ----------------------------------------
`define PHS_CTRL_OFS 5'h00
`define PHS_DEBOUNCE_OFS 5'h04
`define PHS_STATUS_OFS 5'h08
`define PHS_IRQ_STATUS_OFS 5'h0C
`define PHS_IRQ_MASK_OFS 5'h10

// ----------------------------------------
// fields and reset values
// ----------------------------------------
`define PHS_CTRL_SB_AUTO_BIT 0
`define PHS_CTRL_RST 1'h1
`define PHS_DEBOUNCE_RST 8'h14
`define PHS_IRQ_PG_RISE_BIT 0
`define PHS_IRQ_PG_FALL_BIT 1
`define PHS_IRQ_FAULT_BIT 2
`define PHS_IRQ_MAINS_LOSS_BIT 3
`define PHS_IRQ_SB_SHORT_BIT 4
`define PHS_RESP_OKAY 2'h0
`define PHS_RESP_SLVERR 2'h2

`endif

//--- hdl/phs_pkg.sv
// types of the supply sequencer
package phs_pkg;

	typedef enum logic [3:0] {
		ST_OFF, ST_RAMP, ST_RAMP33, ST_PG_WAIT, ST_ON, ST_HOLD, ST_WARN, ST_DECAY, ST_LATCH
	} phs_state_t;

	typedef struct packed {
		logic s1;
		logic s2;
		logic [7:0] cnt;
		logic stable_n;
	} phs_deb_regs_t;

	typedef struct packed {
		phs_state_t st;
		logic [10:0] timer;
		logic [10:0] on_timer;
		logic [16:0] presc;
		logic tick;
		logic sb_latch;
		logic req_prev;
		logic sb_auto;
		logic [7:0] deb;
		logic [4:0] irq_stat;
		logic [4:0] irq_mask;
		logic irq;
		logic aw_full;
		logic [4:0] awaddr;
		logic w_full;
		logic [7:0] wdata;
		logic wstrb0;
		logic bvalid;
		logic [1:0] bresp;
		logic rvalid;
		logic [31:0] rdata;
		logic [1:0] rresp;
		logic pg;
		logic main_en;
		logic en33;
		logic fan;
	} phs_regs_t;

endpackage

//--- hdl/phs_debounce.sv
// synchroniser and tick-based debounce filter for the turn-on request
`include "phs_defs.svh"

module phs_debounce (
	input wire logic core_clk,
	input wire logic resetn,
	input wire logic clk_en,
	input wire logic tick,
	input wire logic raw_n,
	input wire logic [7:0] threshold,
	output logic stable_n
);
	import phs_pkg::*;

	phs_deb_regs_t r;
	phs_deb_regs_t next_r;

	// only the second stage feeds the filter, s1 is read by s2 alone
	always_comb begin
		next_r = r;
		next_r.s1 = raw_n;
		next_r.s2 = r.s1;
		if (r.s2 == r.stable_n) begin
			next_r.cnt = 8'h00;
		end else if (tick) begin
			// a level counts only after it held for threshold + 1 ticks
			if (r.cnt >= threshold) begin
				next_r.stable_n = r.s2;
				next_r.cnt = 8'h00;
			end else begin
				next_r.cnt = r.cnt + 8'h01;
			end
		end
	end

	always_ff @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			r <= '{s1: 1'b1, s2: 1'b1, cnt: 8'h00, stable_n: 1'b1};
		end else if (clk_en) begin
			r <= next_r;
		end
	end

	assign stable_n = r.stable_n;
endmodule

//--- hdl/phs_sequencer.sv
// supply housekeeping sequencer with axi4-lite registers and interrupt
// ----------------------------------------
// ----------------------------------------
`include "phs_defs.svh"

module phs_sequencer #(
	parameter int TICK_CYCLES = `PHS_TICK_CYCLES
) (
	input wire logic core_clk,
	input wire logic resetn,
	input wire logic clk_en,
	input wire logic supply_on_request_n,
	output logic request_pullup_en,
	input wire logic mains_present,
	input wire logic bulk_energy_ok,
	input wire logic rail_12v_ok,
	input wire logic rail_5v_ok,
	input wire logic rail_3v3_ok,
	input wire logic short_12v,
	input wire logic short_5v,
	input wire logic short_3v3,
	input wire logic standby_short,
	output logic main_rail_en,
	output logic rail_3v3_en,
	output logic standby_rail_en,
	output logic power_good_out,
	output logic fan_en,
	output logic irq,
	input wire logic [31:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [31:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready
);
	import phs_pkg::*;

	// ----------------------------------------
	// helpers
	// ----------------------------------------
	localparam logic [16:0] PRESC_LAST = 17'(TICK_CYCLES - 1);
	localparam logic [10:0] PG_DELAY = 11'(`PHS_PG_DELAY_TICKS);
	localparam logic [10:0] MAIN_ON = 11'(`PHS_MAIN_ON_TICKS);
	localparam logic [10:0] LAG_33 = 11'(`PHS_LAG_33_TICKS);
	localparam logic [10:0] MAINS_HOLD = 11'(`PHS_MAINS_HOLD_TICKS);
	localparam logic [10:0] WARN = 11'(`PHS_WARN_TICKS);
	localparam logic [10:0] OFF_MIN = 11'(`PHS_OFF_MIN_TICKS);

	// saturating tick counter, so long waits never wrap
	function automatic logic [10:0] tick_inc(input logic [10:0] v, input logic t);
		tick_inc = (t && v != 11'h7FF) ? v + 11'h001 : v;
	endfunction

	function automatic logic known_ofs(input logic [4:0] a);
		known_ofs = (a == `PHS_CTRL_OFS) || (a == `PHS_DEBOUNCE_OFS) ||
			(a == `PHS_STATUS_OFS) || (a == `PHS_IRQ_STATUS_OFS) || (a == `PHS_IRQ_MASK_OFS);
	endfunction

	phs_regs_t r;
	phs_regs_t next_r;
	logic req_n;
	logic req_on;
	logic any_short;
	logic rails_ok;
	logic wr_go;
	logic rd_go;

	phs_debounce u_debounce (
		.core_clk(core_clk),
		.resetn(resetn),
		.clk_en(clk_en),
		.tick(r.tick),
		.raw_n(supply_on_request_n),
		.threshold(r.deb),
		.stable_n(req_n)
	);

	assign req_on = !req_n;
	assign any_short = short_12v | short_5v | short_3v3;
	assign rails_ok = rail_12v_ok & rail_5v_ok & rail_3v3_ok;

	// readies are gated by the enable so no aw, w or ar handshake completes while frozen
	assign s_axi_awready = clk_en & !r.aw_full;
	assign s_axi_wready = clk_en & !r.w_full;
	assign s_axi_arready = clk_en & !r.rvalid;
	assign wr_go = r.aw_full & r.w_full & !r.bvalid;
	assign rd_go = s_axi_arvalid & s_axi_arready;

	// ----------------------------------------
	// next state
	// ----------------------------------------
	always_comb begin
		logic [4:0] ev;
		logic [4:0] clr;
		logic [4:0] ra;
		ev = 5'h00;
		clr = 5'h00;
		ra = s_axi_araddr[4:0];
		next_r = r;

		// single timebase, every delay compares against it
		next_r.tick = 1'b0;
		if (r.presc >= PRESC_LAST) begin
			next_r.presc = 17'h00000;
			next_r.tick = 1'b1;
		end else begin
			next_r.presc = r.presc + 17'h00001;
		end
		next_r.timer = tick_inc(r.timer, r.tick);
		next_r.on_timer = tick_inc(r.on_timer, r.tick);

		// sequencing
		case (r.st)
			ST_OFF: begin
				next_r.main_en = 1'b0;
				next_r.en33 = 1'b0;
				next_r.pg = 1'b0;
				if (req_on && mains_present) begin
					next_r.st = ST_RAMP;
					next_r.main_en = 1'b1;
					next_r.on_timer = 11'h000;
				end
			end
			ST_RAMP: begin
				// 3.3 V waits until both higher rails regulate
				if (rail_12v_ok && rail_5v_ok) begin
					next_r.st = ST_RAMP33;
					next_r.en33 = 1'b1;
					next_r.timer = 11'h000;
				end else if (r.on_timer >= MAIN_ON) begin
					next_r.st = ST_LATCH;
				end
			end
			ST_RAMP33: begin
				if (rails_ok) begin
					next_r.st = ST_PG_WAIT;
					next_r.timer = 11'h000;
				end else if (r.timer >= LAG_33 || r.on_timer >= MAIN_ON) begin
					next_r.st = ST_LATCH;
				end
			end
			ST_PG_WAIT: begin
				if (!rails_ok) begin
					next_r.st = ST_LATCH;
				end else if (r.timer >= PG_DELAY && bulk_energy_ok) begin
					next_r.st = ST_ON;
					next_r.pg = 1'b1;
					ev[`PHS_IRQ_PG_RISE_BIT] = 1'b1;
				end
			end
			ST_ON: begin
				if (!rails_ok) begin
					next_r.st = ST_LATCH;
				end else if (!mains_present || !bulk_energy_ok) begin
					next_r.st = ST_HOLD;
					next_r.timer = 11'h000;
					ev[`PHS_IRQ_MAINS_LOSS_BIT] = !mains_present;
				end else if (!req_on) begin
					next_r.st = ST_WARN;
					next_r.pg = 1'b0;
					next_r.timer = 11'h000;
				end
			end
			ST_HOLD: begin
				if (!rails_ok) begin
					next_r.st = ST_LATCH;
				end else if (mains_present && bulk_energy_ok) begin
					next_r.st = ST_ON;
				end else if (r.timer >= MAINS_HOLD) begin
					next_r.st = ST_WARN;
					next_r.pg = 1'b0;
					next_r.timer = 11'h000;
				end
			end
			ST_WARN: begin
				// rails stay on so power good falls before any of them does
				if (r.timer >= WARN) begin
					next_r.st = ST_DECAY;
					next_r.main_en = 1'b0;
					next_r.en33 = 1'b0;
				end
			end
			ST_DECAY: begin
				// requests are ignored until the rails are gone
				if (!rail_12v_ok && !rail_5v_ok && !rail_3v3_ok) begin
					next_r.st = ST_OFF;
				end
			end
			ST_LATCH: begin
				next_r.main_en = 1'b0;
				next_r.en33 = 1'b0;
				next_r.pg = 1'b0;
				if (req_on || any_short) begin
					next_r.timer = 11'h000;
				end else if (r.timer >= OFF_MIN) begin
					next_r.st = ST_OFF;
				end
			end
			default: begin
				next_r.st = ST_OFF;
			end
		endcase

		// shorts latch from any state that drives the rails
		if (any_short && r.main_en) begin
			next_r.st = ST_LATCH;
			next_r.timer = 11'h000;
		end
		if (next_r.st == ST_LATCH && r.st != ST_LATCH) begin
			next_r.pg = 1'b0;
			next_r.main_en = 1'b0;
			next_r.en33 = 1'b0;
			next_r.timer = 11'h000;
			ev[`PHS_IRQ_FAULT_BIT] = 1'b1;
		end
		if (r.pg && !next_r.pg) begin
			ev[`PHS_IRQ_PG_FALL_BIT] = 1'b1;
		end

		// standby rail
		next_r.req_prev = req_on;
		if (standby_short) begin
			if (!r.sb_latch) begin
				ev[`PHS_IRQ_SB_SHORT_BIT] = 1'b1;
			end
			next_r.sb_latch = 1'b1;
		end else if (r.sb_auto || (req_on && !r.req_prev)) begin
			next_r.sb_latch = 1'b0;
		end

		next_r.fan = req_on && next_r.main_en;

		// register writes
		if (s_axi_awvalid && s_axi_awready) begin
			next_r.aw_full = 1'b1;
			next_r.awaddr = s_axi_awaddr[4:0];
		end
		if (s_axi_wvalid && s_axi_wready) begin
			next_r.w_full = 1'b1;
			next_r.wdata = s_axi_wdata[7:0];
			next_r.wstrb0 = s_axi_wstrb[0];
		end
		if (wr_go) begin
			next_r.aw_full = 1'b0;
			next_r.w_full = 1'b0;
			next_r.bvalid = 1'b1;
			next_r.bresp = known_ofs(r.awaddr) ? `PHS_RESP_OKAY : `PHS_RESP_SLVERR;
			if (r.wstrb0) begin
				case (r.awaddr)
					`PHS_CTRL_OFS: next_r.sb_auto = r.wdata[`PHS_CTRL_SB_AUTO_BIT];
					`PHS_DEBOUNCE_OFS: next_r.deb = r.wdata;
					`PHS_IRQ_STATUS_OFS: clr = r.wdata[4:0];
					`PHS_IRQ_MASK_OFS: next_r.irq_mask = r.wdata[4:0];
					default: next_r.bresp = next_r.bresp;
				endcase
			end
		end else if (r.bvalid && s_axi_bready) begin
			next_r.bvalid = 1'b0;
		end

		// a new event wins over a clear in the same cycle
		next_r.irq_stat = (r.irq_stat & ~clr) | ev;
		next_r.irq = |(next_r.irq_stat & next_r.irq_mask);

		// register reads
		if (rd_go) begin
			next_r.rvalid = 1'b1;
			next_r.rresp = known_ofs(ra) ? `PHS_RESP_OKAY : `PHS_RESP_SLVERR;
			case (ra)
				`PHS_CTRL_OFS: next_r.rdata = {31'h00000000, r.sb_auto};
				`PHS_DEBOUNCE_OFS: next_r.rdata = {24'h000000, r.deb};
				`PHS_STATUS_OFS: next_r.rdata = {20'h00000, r.st, r.sb_latch, req_on,
					r.fan, r.en33, r.main_en, r.pg, rail_3v3_ok, rail_5v_ok & rail_12v_ok};
				`PHS_IRQ_STATUS_OFS: next_r.rdata = {27'h0000000, r.irq_stat};
				`PHS_IRQ_MASK_OFS: next_r.rdata = {27'h0000000, r.irq_mask};
				default: next_r.rdata = 32'h00000000;
			endcase
		end else if (r.rvalid && s_axi_rready) begin
			next_r.rvalid = 1'b0;
		end
	end

	// ----------------------------------------
	// state register
	// ----------------------------------------
	always_ff @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			r <= '0;
			r.st <= ST_OFF;
			r.sb_auto <= `PHS_CTRL_RST;
			r.deb <= `PHS_DEBOUNCE_RST;
		end else if (clk_en) begin
			r <= next_r;
		end
	end

	// ----------------------------------------
	// outputs
	// ----------------------------------------
	assign request_pullup_en = 1'b1;
	assign main_rail_en = r.main_en;
	assign rail_3v3_en = r.en33;
	// standby needs no sequencing, it follows mains at once unless a standby short has latched it off
	assign standby_rail_en = mains_present & !r.sb_latch;
	assign power_good_out = r.pg;
	assign fan_en = r.fan;
	assign irq = r.irq;
	assign s_axi_bvalid = r.bvalid;
	assign s_axi_bresp = r.bresp;
	assign s_axi_rvalid = r.rvalid;
	assign s_axi_rdata = r.rdata;
	assign s_axi_rresp = r.rresp;
endmodule

//--- verification/phs_board_model.sv
// board side model: drives the turn-on request, emulates rail ramp and decay
module phs_board_model #(
	parameter int RAMP = 40,
	parameter int DECAY = 600
) (
	input wire logic core_clk,
	input wire logic want,
	input wire logic main_rail_en,
	input wire logic rail_3v3_en,
	input wire logic short_5v,
	output logic supply_on_request_n,
	output logic rail_12v_ok,
	output logic rail_5v_ok,
	output logic rail_3v3_ok
);
	logic req_n = 1'b1;
	int lv_m = 0;
	int lv_3 = 0;
	// ----
	// rails stay in regulation for a while after disable, as bulk caps discharge
	// ----
	always @(posedge core_clk) begin
		req_n <= !want;
		lv_m <= main_rail_en ? (lv_m >= RAMP ? DECAY : lv_m + 1) : (lv_m > 0 ? lv_m - 1 : 0);
		lv_3 <= rail_3v3_en ? (lv_3 >= RAMP ? DECAY : lv_3 + 1) : (lv_3 > 0 ? lv_3 - 1 : 0);
	end
	assign supply_on_request_n = req_n;
	assign rail_12v_ok = lv_m >= RAMP;
	// a shorted rail collapses at once
	assign rail_5v_ok = lv_m >= RAMP && !short_5v;
	assign rail_3v3_ok = lv_3 >= RAMP;
endmodule

//--- verification/phs_sequencer_monitor.sv
// assertion checker for the supply sequencer ports
module phs_sequencer_monitor #(
	parameter int TICK_CYCLES = 10
) (
	input wire logic core_clk,
	input wire logic resetn,
	input wire logic request_pullup_en,
	input wire logic mains_present,
	input wire logic bulk_energy_ok,
	input wire logic rail_12v_ok,
	input wire logic rail_5v_ok,
	input wire logic rail_3v3_ok,
	input wire logic short_12v,
	input wire logic short_5v,
	input wire logic short_3v3,
	input wire logic main_rail_en,
	input wire logic rail_3v3_en,
	input wire logic standby_rail_en,
	input wire logic power_good_out
);
	logic ok3, sh;
	int ok_n, loss_n, low_n;
	assign ok3 = rail_12v_ok && rail_5v_ok && rail_3v3_ok;
	assign sh = short_12v || short_5v || short_3v3;
	default clocking cb @(posedge core_clk);
	endclocking
	default disable iff (!resetn);
	// ----
	// cycle counters behind the timing checks
	// ----
	always_ff @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			ok_n <= 0;
			loss_n <= 0;
			low_n <= 0;
		end else begin
			ok_n <= ok3 ? ok_n + 1 : 0;
			loss_n <= mains_present ? 0 : loss_n + 1;
			low_n <= power_good_out ? 0 : low_n + 1;
		end
	end
	chk_pg_rails: assert property (
		$rose(power_good_out) |-> $past(ok3 && bulk_energy_ok)) else $error("pg rose early");
	chk_pg_uv: assert property (
		power_good_out && !ok3 |=> !power_good_out) else $error("pg kept on undervoltage");
	chk_pg_delay: assert property (
		$rose(power_good_out) |-> ok_n >= 100 * TICK_CYCLES && ok_n <= 500 * TICK_CYCLES)
		else $error("pg delay out of range");
	chk_pg_warn: assert property (
		$fell(main_rail_en) && $past(ok3) && !$past(sh) |-> low_n >= TICK_CYCLES)
		else $error("no warning before rails off");
	chk_hold_time: assert property (
		$fell(power_good_out) && !mains_present && $past(ok3) |-> loss_n >= 16 * TICK_CYCLES)
		else $error("pg hold too short");
	chk_sb_mains: assert property (
		standby_rail_en |-> mains_present) else $error("standby on without mains");
	chk_pullup_on: assert property (
		request_pullup_en) else $error("pull-up off");
	chk_33_order: assert property (
		rail_3v3_en |-> main_rail_en) else $error("3v3 enabled alone");
	chk_short_off: assert property (
		main_rail_en && sh |-> ##[1:3] (!main_rail_en && !power_good_out))
		else $error("short did not latch off");
endmodule
bind phs_sequencer phs_sequencer_monitor #(.TICK_CYCLES(TICK_CYCLES)) i_mon (.*);

//--- verification/tb_phs_sequencer.sv
// self-checking bench of the supply sequencer
`include "phs_defs.svh"
module tb_phs_sequencer;
	timeunit 1ns;
	timeprecision 1ns;
	localparam int T = 10;
	logic core_clk = 0, resetn = 0, want = 0, mains_present = 1, short_5v = 0, standby_short = 0;
	logic clk_en = 1, bulk_energy_ok = 1, short_12v = 0, short_3v3 = 0;
	logic supply_on_request_n, request_pullup_en, rail_12v_ok, rail_5v_ok, rail_3v3_ok;
	logic main_rail_en, rail_3v3_en, standby_rail_en, power_good_out, fan_en, irq;
	logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0;
	logic s_axi_rready = 0, s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
	logic s_axi_rvalid;
	logic [31:0] s_axi_awaddr = 0, s_axi_wdata = 0, s_axi_araddr = 0, s_axi_rdata;
	logic [3:0] s_axi_wstrb = 0;
	logic [1:0] s_axi_bresp, s_axi_rresp;
	int errors = 0, samples_checked = 0;
	phs_sequencer #(.TICK_CYCLES(T)) i_dut (.*);
	phs_board_model i_brd (.*);
	always #5 core_clk = ~core_clk;
	// ----
	// shared tasks; readies are read 1 ns after an edge, where they stand till the next
	// ----
	task automatic cyc(input int n);
		repeat (n) @(posedge core_clk);
	endtask
	task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			errors++;
			$display("Error %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	task automatic wr(input logic [4:0] a, input logic [31:0] d, output logic [1:0] r);
		logic da, dw, ta, tw, b;
		s_axi_awaddr <= {27'h0, a};
		s_axi_wdata <= d;
		s_axi_wstrb <= 4'hF;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		da = 0;
		dw = 0;
		b = 0;
		while (!b) begin
			#1;
			ta = !da && s_axi_awready;
			tw = !dw && s_axi_wready;
			b = s_axi_bvalid;
			r = s_axi_bresp;
			@(posedge core_clk);
			if (ta) s_axi_awvalid <= 1'b0;
			if (tw) s_axi_wvalid <= 1'b0;
			da |= ta;
			dw |= tw;
		end
		s_axi_bready <= 1'b0;
	endtask
	task automatic rd(input logic [4:0] a, output logic [31:0] d, output logic [1:0] r);
		logic t, v;
		s_axi_araddr <= {27'h0, a};
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		v = 0;
		while (!v) begin
			#1;
			t = s_axi_arready;
			v = s_axi_rvalid;
			d = s_axi_rdata;
			r = s_axi_rresp;
			@(posedge core_clk);
			if (t) s_axi_arvalid <= 1'b0;
		end
		s_axi_rready <= 1'b0;
	endtask
	task automatic wt(input bit m, input logic v, output int n);
		n = 0;
		do begin
			@(posedge core_clk);
			#1;
			n++;
		end while ((m ? main_rail_en : power_good_out) !== v && n < 12000);
		@(posedge core_clk);
	endtask
	task automatic stop_test;
		$display("errors %0d samples_checked %0d", errors, samples_checked);
		if (errors == 0 && samples_checked > 0) $display("SIMULATION PASSED");
		else $display("SIMULATION FAILED");
		$finish;
	endtask
	// ----
	// scenarios
	// ----
	task automatic t_regs;
		logic [31:0] d;
		logic [1:0] r;
		chk("sb up", standby_rail_en, 1'b1);
		rd(`PHS_CTRL_OFS, d, r);
		chk("ctrl", d, 32'h1);
		rd(`PHS_DEBOUNCE_OFS, d, r);
		chk("debounce", d, 32'h14);
		rd(`PHS_IRQ_MASK_OFS, d, r);
		chk("mask", d, 32'h0);
		rd(5'h14, d, r);
		chk("bad rd", {30'h0, r}, 32'h2);
		wr(5'h18, 32'h1, r);
		chk("bad wr", {30'h0, r}, 32'h2);
		wr(`PHS_DEBOUNCE_OFS, 32'h2, r);
		wr(`PHS_IRQ_MASK_OFS, 32'h1F, r);
		standby_short <= 1'b1;
		cyc(3);
		#1;
		chk("sb short", standby_rail_en, 1'b0);
		chk("irq set", irq, 1'b1);
		cyc(1);
		standby_short <= 1'b0;
		cyc(3);
		#1;
		chk("sb back", standby_rail_en, 1'b1);
		cyc(1);
		wr(`PHS_IRQ_STATUS_OFS, 32'h1F, r);
		cyc(2);
		#1;
		chk("irq clr", irq, 1'b0);
		cyc(1);
	endtask
	task automatic t_on_off;
		int n;
		logic [31:0] d;
		logic [1:0] r;
		want <= 1'b1;
		cyc(8);
		want <= 1'b0;
		cyc(60);
		#1;
		chk("glitch", main_rail_en, 1'b0);
		cyc(1);
		want <= 1'b1;
		wt(0, 1, n);
		#1;
		chk("rails on", main_rail_en && rail_3v3_en, 1'b1);
		chk("fan on", fan_en, 1'b1);
		chk("irq rise", irq, 1'b1);
		cyc(1);
		rd(`PHS_IRQ_STATUS_OFS, d, r);
		chk("pg event", d[0], 1'b1);
		wr(`PHS_IRQ_STATUS_OFS, 32'h1, r);
		want <= 1'b0;
		wt(0, 0, n);
		wt(1, 0, n);
		// pg fell one edge before the second wait began counting
		chk("warning", n + 1 >= T, 1'b1);
		#1;
		chk("fan off", fan_en, 1'b0);
		chk("3v3 off", rail_3v3_en, 1'b0);
		cyc(800);
	endtask
	task automatic t_mains;
		int n;
		want <= 1'b1;
		wt(0, 1, n);
		mains_present <= 1'b0;
		wt(0, 0, n);
		chk("hold", n >= 16 * T && n <= 20 * T, 1'b1);
		chk("sb loss", standby_rail_en, 1'b0);
		mains_present <= 1'b1;
		want <= 1'b0;
		cyc(1000);
	endtask
	task automatic t_decay;
		int n;
		logic [31:0] d;
		logic [1:0] r;
		want <= 1'b1;
		wt(0, 1, n);
		want <= 1'b0;
		wt(1, 0, n);
		want <= 1'b1;
		cyc(15 * T);
		want <= 1'b0;
		cyc(800);
		rd(`PHS_STATUS_OFS, d, r);
		chk("no latch", d[11:8], 4'h0);
		want <= 1'b1;
		wt(0, 1, n);
		chk("restart", n < 800 * T, 1'b1);
	endtask
	task automatic t_latch;
		int n;
		short_5v <= 1'b1;
		cyc(5);
		short_5v <= 1'b0;
		#1;
		chk("latched", main_rail_en || power_good_out, 1'b0);
		cyc(1);
		want <= 1'b0;
		cyc(500 * T);
		want <= 1'b1;
		cyc(60 * T);
		#1;
		chk("held off", main_rail_en, 1'b0);
		cyc(1);
		want <= 1'b0;
		cyc(1040 * T);
		want <= 1'b1;
		wt(0, 1, n);
		chk("resumed", n < 800 * T, 1'b1);
	endtask
	initial begin
		cyc(12);
		resetn <= 1'b1;
		cyc(1);
		t_regs();
		t_on_off();
		t_mains();
		t_decay();
		t_latch();
		stop_test();
	end
	initial begin
		cyc(60000);
		errors++;
		stop_test();
	end
endmodule
